/* File: inc/motor_bridge_defs.vh */
// Timing constants and input command codes for the dual bridge motor control logic.
`ifndef MOTOR_BRIDGE_DEFS_VH
`define MOTOR_BRIDGE_DEFS_VH
`define CLOCK_MHZ 100
`define STANDBY_DELAY_US 1000
`define STANDBY_DELAY_CYCLES (`STANDBY_DELAY_US * `CLOCK_MHZ)
`define FAULT_QUALIFY_US 2
`define FAULT_QUALIFY_CYCLES (`FAULT_QUALIFY_US * `CLOCK_MHZ)
`define RETRY_HOLDOFF_US 2000
`define RETRY_HOLDOFF_CYCLES (`RETRY_HOLDOFF_US * `CLOCK_MHZ)
`define CODE_COAST 2'h0
`define CODE_FORWARD 2'h2
`define CODE_REVERSE 2'h1
`define CODE_BRAKE 2'h3
`endif

/* File: rtl/bridge_channel.v */
// One full bridge: input decode, overcurrent qualification, shutdown and retry hold-off.
`timescale 1ns/1ps
`include "motor_bridge_defs.vh"
module bridge_channel #(
    parameter QUALIFY_CYCLES = `FAULT_QUALIFY_CYCLES,
    parameter HOLDOFF_CYCLES = `RETRY_HOLDOFF_CYCLES
) (
    input wire clock,
    input wire rst_b,
    input wire enable,
    input wire forwardIn,
    input wire reverseIn,
    input wire [1:0] highCurrentOver,
    input wire [1:0] lowVoltageOver,
    output reg [1:0] highOn,
    output reg [1:0] lowOn,
    output wire faultActive
);
    localparam ST_RUN = 1'b0;
    localparam ST_HOLD = 1'b1;
    reg state_r;
    reg [7:0] qualCount_r;
    reg [23:0] holdCount_r;
    reg [1:0] hiNxt;
    reg [1:0] loNxt;
    wire [1:0] hiSense;
    wire [1:0] loSense;
    wire overNow;
    wire tripNow;

    // High-side current is only meaningful once that driver is conducting. [RQ4]
    assign hiSense = highCurrentOver & highOn;
    assign loSense = lowVoltageOver & lowOn; // [RQ5]
    assign overNow = |{hiSense, loSense};
    assign tripNow = overNow && (qualCount_r >= QUALIFY_CYCLES[7:0]); // [RQ4] [RQ5]
    assign faultActive = (state_r == ST_HOLD);

    always @* begin
        hiNxt = 2'h0;
        loNxt = 2'h0;
        case ({forwardIn, reverseIn}) // [RQ11] [RQ12]
            `CODE_FORWARD: begin
                hiNxt = 2'h1;
                loNxt = 2'h2;
            end
            `CODE_REVERSE: begin
                hiNxt = 2'h2;
                loNxt = 2'h1;
            end
            `CODE_BRAKE: begin
                loNxt = 2'h3;
            end
            default: begin
                hiNxt = 2'h0;
                loNxt = 2'h0;
            end
        endcase
        if (!enable || state_r == ST_HOLD || tripNow) begin // [RQ6] [RQ7]
            hiNxt = 2'h0;
            loNxt = 2'h0;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_RUN;
            qualCount_r <= 8'h00;
            holdCount_r <= 24'h000000;
            highOn <= 2'h0;
            lowOn <= 2'h0;
        end else begin
            highOn <= hiNxt;
            lowOn <= loNxt;
            case (state_r)
                ST_RUN: begin
                    if (tripNow) begin // [RQ6]
                        state_r <= ST_HOLD;
                        qualCount_r <= 8'h00;
                        holdCount_r <= 24'h000000;
                    end else if (overNow) begin
                        qualCount_r <= qualCount_r + 8'h01;
                    end else begin
                        qualCount_r <= 8'h00;
                    end
                end
                ST_HOLD: begin
                    // Commands are ignored for the whole hold-off, then the drive is retried. [RQ7]
                    if (holdCount_r >= HOLDOFF_CYCLES[23:0] - 24'h000001) begin
                        state_r <= ST_RUN;
                    end else begin
                        holdCount_r <= holdCount_r + 24'h000001;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end
endmodule // bridge_channel

/* File: rtl/dual_bridge_motor_control_logic.v */
// Top level of the dual full-bridge motor control logic with sleep and protection.
`timescale 1ns/1ps
`include "motor_bridge_defs.vh"
// Notes on behaviour
// (RQ1) All four inputs low continuously for more than 1 ms puts the device to sleep.
// (RQ2) In sleep every output is high impedance and the internal logic is idle; here a bridge's hold-off count keeps running.
// (RQ3) Any input going high wakes the device at once and restarts the standby count.
// (RQ4) A conducting high-side driver above its current limit for over 2 us flags a fault.
// (RQ5) A conducting low-side driver above its voltage limit for over 2 us flags a fault.
// (RQ6) A fault at once switches off both halves of that bridge.
// (RQ7) After a fault the bridge ignores its commands for 2 ms and then retries.
// (RQ8) Each bridge has its own fault detection, shutdown and retry timing.
// (RQ9) Over-temperature disables every output until the sensor reports the hysteresis recovery.
// (RQ10) While supply undervoltage is indicated all drivers stay off.
// (RQ11) Per bridge, 00 coasts, 10 drives forward, 01 drives reverse and 11 brakes.
// (RQ12) High means high side on, low means low side on, off means both off.
// (RQ13) The controller steps a stepper through the full or half step input sequences.
// (RQ14) The controller modulates with 00 or 11 and keeps 00 gaps under 1 ms.
// (RQ15) For paralleled use the controller drives both bridges with identical inputs.
module dual_bridge_motor_control_logic #(
    parameter STANDBY_CYCLES = `STANDBY_DELAY_CYCLES,
    parameter QUALIFY_CYCLES = `FAULT_QUALIFY_CYCLES,
    parameter HOLDOFF_CYCLES = `RETRY_HOLDOFF_CYCLES
) (
    input wire clock,
    input wire rst_b,
    input wire bridge_a_forward_input,
    input wire bridge_a_reverse_input,
    input wire bridge_b_forward_input,
    input wire bridge_b_reverse_input,
    input wire [3:0] highCurrentOver,
    input wire [3:0] lowVoltageOver,
    input wire thermalTrip,
    input wire supply_low_lockout,
    output wire [3:0] highSideOn,
    output wire [3:0] lowSideOn,
    output wire [3:0] outputEnable,
    output wire sleeping,
    output wire [1:0] bridgeFault
);
    reg [23:0] standbyCount_r;
    reg sleep_r;
    wire anyHigh;
    wire runEnable;
    wire [3:0] cmdIn;

    assign cmdIn = {bridge_b_reverse_input, bridge_b_forward_input,
                    bridge_a_reverse_input, bridge_a_forward_input};
    assign anyHigh = |cmdIn;

    // The thermal input is expected to carry its own hysteresis, so only its level is used here.
    assign runEnable = !sleep_r && !thermalTrip && !supply_low_lockout; // [RQ2] [RQ9] [RQ10]
    assign sleeping = sleep_r;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            standbyCount_r <= 24'h000000;
            sleep_r <= 1'b0;
        end else if (anyHigh) begin
            standbyCount_r <= 24'h000000; // [RQ3]
            sleep_r <= 1'b0; // [RQ3]
        end else if (!sleep_r) begin
            if (standbyCount_r >= STANDBY_CYCLES[23:0]) begin
                sleep_r <= 1'b1; // [RQ1]
            end else begin
                standbyCount_r <= standbyCount_r + 24'h000001;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gBridge
            // Separate instances keep fault timing of one bridge away from the other. [RQ8]
            bridge_channel #(
                .QUALIFY_CYCLES(QUALIFY_CYCLES),
                .HOLDOFF_CYCLES(HOLDOFF_CYCLES)
            ) uChannel (
                .clock(clock),
                .rst_b(rst_b),
                .enable(runEnable),
                .forwardIn(cmdIn[2*g]),
                .reverseIn(cmdIn[2*g+1]),
                .highCurrentOver(highCurrentOver[2*g+1:2*g]),
                .lowVoltageOver(lowVoltageOver[2*g+1:2*g]),
                .highOn(highSideOn[2*g+1:2*g]),
                .lowOn(lowSideOn[2*g+1:2*g]),
                .faultActive(bridgeFault[g])
            );
        end
    endgenerate

    // An output is driven only while one of its two transistors is on; otherwise it floats.
    assign outputEnable = highSideOn | lowSideOn; // [RQ2] [RQ12]
endmodule // dual_bridge_motor_control_logic

/* File: tb/step_controller_model.sv */
// Controller model that walks the stepper input sequences, first input in the top bit.
`timescale 1ns/1ps
module step_controller_model (
    input wire clock, run, half,
    output reg [3:0] code = 4'h0);
    reg [2:0] idx_r = 3'h0;
    // Full steps are every second half-step entry, so one table serves both modes.
    wire [31:0] seq = 32'hA2645198;
    always @(posedge clock) begin
        code <= #1 run ? seq[31 - 4 * idx_r -: 4] : 4'h0;
        idx_r <= run ? idx_r + (half ? 3'h1 : 3'h2) : 3'h0;
    end
endmodule // step_controller_model

/* File: tb/motor_chk_assertions.sv */
// Checker of drive, sleep and fault timing at the block's ports.
`timescale 1ns/1ps
module motor_chk #(parameter int STANDBY_CYCLES = 20, QUALIFY_CYCLES = 4, HOLDOFF_CYCLES = 30) (
    input wire clock, rst_b, bridge_a_forward_input, bridge_a_reverse_input, bridge_b_forward_input,
    input wire bridge_b_reverse_input, thermalTrip, supply_low_lockout, sleeping,
    input wire [3:0] highCurrentOver, lowVoltageOver, highSideOn, lowSideOn, outputEnable,
    input wire [1:0] bridgeFault);
    wire [3:0] c = {bridge_a_forward_input, bridge_a_reverse_input, bridge_b_forward_input, bridge_b_reverse_input};
    wire [7:0] want = {c[0] & !c[1], c[1] & !c[0], c[2] & !c[3], c[3] & !c[2], c[1], c[0], c[3], c[2]};
    wire quiet = !thermalTrip && !supply_low_lockout && !sleeping && {bridgeFault, highCurrentOver, lowVoltageOver} == 0;
    reg [31:0] idle_r = 0, hold_r = 0, qual_r = 0;
    always @(posedge clock or negedge rst_b) idle_r <= !rst_b || c != 4'h0 ? 0 : idle_r + 1;
    always @(posedge clock or negedge rst_b) hold_r <= !rst_b || !bridgeFault[0] ? 0 : hold_r + 1;
    always @(posedge clock or negedge rst_b) qual_r <= !rst_b || !(|(highCurrentOver[1:0] & highSideOn[1:0])) ? 0 : qual_r + 1;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_dec; quiet |=> {highSideOn, lowSideOn} == $past(want); endproperty
    a_dec: assert property (p_dec) else $error("decode mismatch");
    property p_prot; thermalTrip || supply_low_lockout |=> outputEnable == 4'h0; endproperty
    a_prot: assert property (p_prot) else $error("drive while protected");
    property p_slp; sleeping |-> outputEnable == 4'h0; endproperty
    a_slp: assert property (p_slp) else $error("drive while asleep");
    property p_sin; $rose(sleeping) |-> idle_r >= STANDBY_CYCLES && idle_r <= STANDBY_CYCLES + 2; endproperty
    a_sin: assert property (p_sin) else $error("sleep entry time");
    property p_wake; sleeping && c != 4'h0 |=> !sleeping; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_hold; bridgeFault[0] |-> {highSideOn[1:0], lowSideOn[1:0]} == 4'h0; endproperty
    a_hold: assert property (p_hold) else $error("faulted bridge drives");
    property p_len; $fell(bridgeFault[0]) |-> hold_r == HOLDOFF_CYCLES; endproperty
    a_len: assert property (p_len) else $error("hold-off length");
    property p_qual; $rose(bridgeFault[0]) |-> qual_r >= QUALIFY_CYCLES && qual_r <= QUALIFY_CYCLES + 2; endproperty
    a_qual: assert property (p_qual) else $error("qualify time");
    c_sleep: cover property ($rose(sleeping));
    c_fault: cover property ($rose(bridgeFault[0]));
    c_retry: cover property ($fell(bridgeFault[0]));
endmodule // motor_chk
bind dual_bridge_motor_control_logic motor_chk #(.STANDBY_CYCLES(STANDBY_CYCLES), .QUALIFY_CYCLES(QUALIFY_CYCLES),
    .HOLDOFF_CYCLES(HOLDOFF_CYCLES)) motor_chk_i (.*);

/* File: tb/dual_bridge_motor_control_logic_tb_top.sv */
// Self-checking bench: drives the inputs, queues expected outputs and compares them.
`timescale 1ns/1ps
module dual_bridge_motor_control_logic_tb_top;
    reg clock = 1'b0, rst_b = 1'b0, useM = 1'b0, half = 1'b0;
    reg [13:0] stim = 14'h0;
    reg [31:0] seed = 32'hFA27D22B, cyc = 32'h0;
    reg [42:0] note, notes[$];
    int errors = 0, nCompared = 0;
    wire [3:0] code, hs, ls, oe;
    wire [1:0] bf;
    wire slp;
    wire [3:0] din = useM ? code : stim[3:0];
    initial forever #5 clock = ~clock;
    step_controller_model step_controller_model_i (.clock(clock), .run(useM), .half(half), .code(code));
    dual_bridge_motor_control_logic #(.STANDBY_CYCLES(20), .QUALIFY_CYCLES(4), .HOLDOFF_CYCLES(30))
        dual_bridge_motor_control_logic_i (.clock(clock), .rst_b(rst_b), .bridge_a_forward_input(din[3]),
        .bridge_a_reverse_input(din[2]), .bridge_b_forward_input(din[1]), .bridge_b_reverse_input(din[0]),
        .highCurrentOver(stim[9:6]), .lowVoltageOver(stim[13:10]), .thermalTrip(stim[5]),
        .supply_low_lockout(stim[4]), .highSideOn(hs), .lowSideOn(ls), .outputEnable(oe), .sleeping(slp),
        .bridgeFault(bf));
    function [7:0] dec(input [3:0] d);
        dec = {d[0] & !d[1], d[1] & !d[0], d[2] & !d[3], d[3] & !d[2], d[1], d[0], d[3], d[2]};
    endfunction
    function [31:0] xs;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    endfunction
    task check_out(input [10:0] e);
        nCompared = nCompared + 1;
        // An output is expected to be driven exactly while one of its two drivers is on.
        if ({bf, slp, hs, ls, oe} !== {e, e[7:4] | e[3:0]}) begin
            errors = errors + 1;
            $display("wrong value outputs expected %h seen %h", {e, e[7:4] | e[3:0]}, {bf, slp, hs, ls, oe});
        end
    endtask
    task print_verdict;
        $display("compared %0d errors %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Stimulus holds over-limit, thermal, lockout and command bits so they change in one step.
    task step(input [13:0] s, input [7:0] m, input [2:0] x);
        @(posedge clock) #1 stim = s;
        notes.push_back({cyc + 32'h1, x, dec(s[3:0]) & m});
    endtask
    task fault(input [13:0] s, input [7:0] m, input [2:0] x);
        repeat (4) step(s, 8'hFF, 3'h0);
        repeat (3) @(posedge clock);
        step(s, m, x);
        step(14'h00A, m, x);
        repeat (32) @(posedge clock);
        step(14'h00A, 8'hFF, 3'h0);
    endtask
    always @(posedge clock) #2 if (useM) notes.push_back({cyc + 32'h1, 3'h0, dec(code)});
    always @(negedge clock) if (notes.size() != 0 && notes[0][42:11] == cyc) begin
        note = notes.pop_front();
        check_out(note[10:0]);
    end
    always @(posedge clock) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'h3E8) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        #1 rst_b = 1'b1;
        for (int i = 0; i < 48; i++) step(14'(i < 16 ? i : xs() % 16), 8'hFF, 3'h0);
        step(14'h02A, 8'h00, 3'h0);
        step(14'h01A, 8'h00, 3'h0);
        // Both bridges get the same code, modulated with short coast or brake gaps.
        for (int i = 0; i < 6; i++) step(i[0] ? 14'h000 : 14'h00A, 8'hFF, 3'h0);
        for (int i = 0; i < 6; i++) step(i[0] ? 14'h00F : 14'h005, 8'hFF, 3'h0);
        step(14'h00A, 8'hFF, 3'h0);
        $display("decode and protection done");
        @(posedge clock) #1 useM = 1'b1;
        repeat (8) @(posedge clock);
        #1 half = 1'b1;
        repeat (8) @(posedge clock);
        #1 useM = 1'b0;
        $display("stepper done");
        step(14'h000, 8'hFF, 3'h0);
        repeat (25) @(posedge clock);
        step(14'h000, 8'hFF, 3'h1);
        step(14'h008, 8'h00, 3'h0);
        step(14'h008, 8'hFF, 3'h0);
        $display("sleep done");
        fault(14'h04A, 8'hCC, 3'h2);
        fault(14'h200A, 8'h33, 3'h4);
        $display("fault done");
        // The last expectation is compared one edge later, and any note left behind is a miss.
        repeat (2) @(posedge clock);
        errors = errors + notes.size();
        print_verdict();
    end
endmodule // dual_bridge_motor_control_logic_tb_top
